/* File: dv/pwr_mgmt_monitor.sv */
`timescale 1ns/1ns
module pwr_mgmt_monitor
  import pwr_mgmt_pkg::*;
(
  input logic clk,
  input logic reset,
  input cmp_t cmp_in,
  input reg_req_t req,
  input logic [data_w-1:0] rdata,
  input logic host_out_en,
  input logic backed_supply_out,
  input logic irq,
  input logic tstamp_capture,
  input logic power_fail_det_en,
  input logic switch_thr_mon_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  mode_write_only_a: assert property ($changed(switch_thr_mon_en) |->
    $past(req.wr) || $past(req.wr, 2)) else $error("mode moved");
  rd_refuse_a: assert property (req.rd && !host_out_en |=> rdata == 0)
    else $error("read on battery");
  host_off_a: assert property (host_out_en == !backed_supply_out)
    else $error("host enable");
  bat_cause_a: assert property ($rose(backed_supply_out) |->
    $past(cmp_in.vdd_below_bat, 3)) else $error("bad switch");
  main_back_a: assert property (!cmp_in.vdd_below_bat [*4] |=>
    !backed_supply_out) else $error("stuck on battery");
  stamp_pulse_a: assert property (tstamp_capture |=> !tstamp_capture)
    else $error("stamp long");
  stamp_cause_a: assert property (tstamp_capture |-> $rose(backed_supply_out))
    else $error("stamp cause");
  pfail_off_a: assert property (backed_supply_out [*2] |-> !power_fail_det_en)
    else $error("fail detect on");
endmodule

/* File: dv/supply_model.sv */
`timescale 1ns/1ns
// comparator levels follow the commanded supply state one clock later
module supply_model
  import pwr_mgmt_pkg::*;
(
  input logic clk,
  input cmp_t want,
  output cmp_t cmp_in
);
  always_ff @(posedge clk) begin
    cmp_in <= want;
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import pwr_mgmt_pkg::*;
  logic clk = 0;
  logic reset = 1;
  cmp_t want = '0;
  cmp_t cmp_in;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic hoe, bso, irq, tsc, pfe, thr;
  int miscompares = 0, comparisons = 0, ts_n = 0;
  supply_model i_supply_model (.clk(clk), .want(want), .cmp_in(cmp_in));
  battery_power_management_ctrl i_battery_power_management_ctrl (.clk(clk), .reset(reset),
    .cmp_in(cmp_in), .req(req), .rdata(rdata), .host_out_en(hoe), .backed_supply_out(bso),
    .irq(irq), .tstamp_capture(tsc), .power_fail_det_en(pfe), .switch_thr_mon_en(thr));
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (tsc === 1'b1) ts_n++;
  task chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 0;
  endtask
  task rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  // settle time covers model delay, two sync stages and the output register
  task sup(cmp_t c);
    want <= c;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 0;
    rd(ctrl_offs, 8'h00);
    for (int m = 0; m < 8; m++) begin
      wr(ctrl_offs, 8'(m));
      rd(status_offs, {3'h0, !(m == 2 || m == 5 || m == 7), m == 0 || m == 3, 3'h0});
      chk("pfail_en", 8'(!(m == 2 || m == 5 || m == 7)), 8'(pfe));
      chk("thr_en", 8'(m < 3), 8'(thr));
    end
    $display("test modes end");
    wr(ctrl_offs, 8'h28);
    sup(3'b110);
    chk("bat", 8'h01, 8'(bso));
    chk("irq", 8'h01, 8'(irq));
    chk("host_en", 8'h00, 8'(hoe));
    chk("pfail_en", 8'h00, 8'(pfe));
    rd(status_offs, 8'h00);
    wr(ctrl_offs, 8'h00);
    sup(3'b000);
    chk("stamps", 8'h01, 8'(ts_n));
    chk("irq", 8'h01, 8'(irq));
    rd(ctrl_offs, 8'h28);
    rd(status_offs, 8'h19);
    wr(clear_offs, 8'h01);
    rd(status_offs, 8'h18);
    chk("irq", 8'h00, 8'(irq));
    $display("test switch end");
    sup(3'b100);
    chk("bat", 8'h00, 8'(bso));
    wr(ctrl_offs, 8'h03);
    sup(3'b100);
    chk("bat", 8'h01, 8'(bso));
    chk("thr_en", 8'h00, 8'(thr));
    chk("irq", 8'h00, 8'(irq));
    sup(3'b000);
    wr(ctrl_offs, 8'h06);
    sup(3'b110);
    chk("bat", 8'h00, 8'(bso));
    chk("pfail_en", 8'h01, 8'(pfe));
    rd(status_offs, 8'h10);
    $display("test select end");
    wr(ctrl_offs, 8'h10);
    sup(3'b001);
    rd(status_offs, 8'h1b);
    chk("irq", 8'h01, 8'(irq));
    wr(clear_offs, 8'hff);
    rd(status_offs, 8'h1a);
    sup(3'b000);
    rd(status_offs, 8'h18);
    chk("irq", 8'h00, 8'(irq));
    $display("test low end");
    test_done;
  end
endmodule
bind battery_power_management_ctrl pwr_mgmt_monitor i_mon (.clk, .reset, .cmp_in, .req,
  .rdata, .host_out_en, .backed_supply_out, .irq, .tstamp_capture, .power_fail_det_en,
  .switch_thr_mon_en);

/* File: hw/battery_power_management_ctrl.sv */
`timescale 1ns/1ns
// How it works
// R01: three-bit mode field resets to 000
// R02: mode codes pick standard, direct or disabled
// R03: battery low detect only codes 000, 011
// R04: extra fail detect off for 010,101,111
// R05: codes 110/111 always select main supply
// R06: standard: battery when below battery and threshold
// R07: direct: battery when below battery only
// R08: main-to-battery transition sets switch flag
// R09: switch interrupt only when its enable set
// R10: timestamp capture pulse when enable set
// R11: switch flag holds until host clears or a disabled mode code (110/111) is selected
// R12: host inputs ignored while on battery
// R13: host outputs high-impedance while on battery
// R14: switch flag reads zero when disabled
// R15: battery low sets low flag when active
// R16: battery monitoring continues on battery
// R17: low interrupt only when its enable set
// R18: host cannot clear the battery-low flag
// R19: low flag self-clears when battery recovers
// R20: comparators double-synchronised, edge-triggered flag set
// R21: interrupt is OR of gated requests
module battery_power_management_ctrl
  import pwr_mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire cmp_t cmp_in,
  input wire reg_req_t req,
  output logic [data_w-1:0] rdata,
  output logic host_out_en,
  output logic backed_supply_out,
  output logic irq,
  output logic tstamp_capture,
  output logic power_fail_det_en,
  output logic switch_thr_mon_en
);

  typedef struct packed {
    cmp_t sync1;
    cmp_t sync2;
    logic [2:0] mode;
    logic bsw_irq_en;
    logic blow_irq_en;
    logic bsw_tstamp_en;
    logic on_battery;
    logic bsw_flag;
    logic blow_flag;
    logic blow_prev;
    logic [data_w-1:0] rdata;
    logic host_out_en;
    logic irq;
    logic tstamp;
    logic pfail_en;
    logic thr_en;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  switch_mode_t sw_mode;
  logic blow_active;
  logic pfail_active;
  logic fail_cond;
  logic to_battery;
  logic blow_rise;
  logic host_ok;
  logic [data_w-1:0] rd_val;

  always_comb begin
    unique case (state_ff.mode)
      3'h0, 3'h1, 3'h2: sw_mode = sw_standard; // R02
      3'h3, 3'h4, 3'h5: sw_mode = sw_direct; // R02
      3'h6, 3'h7: sw_mode = sw_disabled; // R02
    endcase
  end

  assign blow_active = (state_ff.mode == 3'h0) || (state_ff.mode == 3'h3); // R03
  assign pfail_active = !((state_ff.mode == 3'h2) || (state_ff.mode == 3'h5)
      || (state_ff.mode == 3'h7)); // R04

  always_comb begin
    unique case (sw_mode)
      sw_standard: fail_cond = state_ff.sync2.vdd_below_bat
          && state_ff.sync2.vdd_below_thr; // R06
      sw_direct: fail_cond = state_ff.sync2.vdd_below_bat; // R07
      default: fail_cond = 1'b0; // R05
    endcase
  end

  // flags set on rising edge of the synchronised condition
  assign to_battery = fail_cond && !state_ff.on_battery; // R08 R20
  // low comparator watched regardless of supply source
  assign blow_rise = blow_active && state_ff.sync2.bat_below_low
      && !state_ff.blow_prev; // R15 R16 R20
  // on battery the host port is dead, writes and reads alike
  assign host_ok = !state_ff.on_battery; // R12

  always_comb begin
    rd_val = '0;
    unique case (req.addr)
      ctrl_offs: begin
        rd_val[mode_lsb +: 3] = state_ff.mode;
        rd_val[bsw_irq_en_pos] = state_ff.bsw_irq_en;
        rd_val[blow_irq_en_pos] = state_ff.blow_irq_en;
        rd_val[bsw_tstamp_en_pos] = state_ff.bsw_tstamp_en;
      end
      status_offs: begin
        rd_val[bsw_flag_pos] = state_ff.bsw_flag && (sw_mode != sw_disabled); // R14
        rd_val[blow_flag_pos] = state_ff.blow_flag;
        rd_val[on_battery_pos] = state_ff.on_battery;
        rd_val[blow_det_pos] = blow_active;
        rd_val[pfail_det_pos] = pfail_active;
      end
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync1 = cmp_in; // R20
    nxt_state.sync2 = state_ff.sync1; // R20
    nxt_state.on_battery = fail_cond;
    nxt_state.blow_prev = blow_active && state_ff.sync2.bat_below_low;
    nxt_state.rdata = '0;
    if (req.rd && host_ok) begin // R12
      nxt_state.rdata = rd_val;
    end
    if (req.wr && host_ok && req.addr == ctrl_offs) begin // R12
      nxt_state.mode = req.wdata[mode_lsb +: 3];
      nxt_state.bsw_irq_en = req.wdata[bsw_irq_en_pos];
      nxt_state.blow_irq_en = req.wdata[blow_irq_en_pos];
      nxt_state.bsw_tstamp_en = req.wdata[bsw_tstamp_en_pos];
    end
    // no write path touches the low flag
    if (req.wr && host_ok && req.addr == clear_offs && req.wdata[clr_bsw_pos]) begin
      nxt_state.bsw_flag = 1'b0; // R11 R18
    end
    if (sw_mode == sw_disabled) begin
      nxt_state.bsw_flag = 1'b0; // R14
    end else if (to_battery) begin
      nxt_state.bsw_flag = 1'b1; // R08
    end
    if (blow_rise) begin
      nxt_state.blow_flag = 1'b1; // R15
    end else if (!state_ff.sync2.bat_below_low || !blow_active) begin
      nxt_state.blow_flag = 1'b0; // R19
    end
    nxt_state.tstamp = to_battery && state_ff.bsw_tstamp_en; // R10
    nxt_state.irq = (nxt_state.bsw_flag && state_ff.bsw_irq_en)
        || (nxt_state.blow_flag && state_ff.blow_irq_en); // R09 R11 R17 R21
    nxt_state.host_out_en = !fail_cond; // R13
    nxt_state.pfail_en = pfail_active && !fail_cond;
    // direct and disabled modes may power down threshold monitoring
    nxt_state.thr_en = (sw_mode == sw_standard); // R07
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= '0;
      state_ff.mode <= mode_rst; // R01
      state_ff.host_out_en <= 1'b1;
      state_ff.pfail_en <= 1'b1;
      state_ff.thr_en <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata = state_ff.rdata;
  assign host_out_en = state_ff.host_out_en;
  assign backed_supply_out = state_ff.on_battery;
  assign irq = state_ff.irq;
  assign tstamp_capture = state_ff.tstamp;
  assign power_fail_det_en = state_ff.pfail_en;
  assign switch_thr_mon_en = state_ff.thr_en;

endmodule

/* File: pkg/pwr_mgmt_pkg.sv */
package pwr_mgmt_pkg;

  localparam int addr_w = 4;
  localparam int data_w = 8;

  // register offsets
  localparam logic [3:0] ctrl_offs = 4'h0;
  localparam logic [3:0] status_offs = 4'h1;
  localparam logic [3:0] clear_offs = 4'h2;

  // control register field positions
  localparam int mode_lsb = 0;
  localparam int bsw_irq_en_pos = 3;
  localparam int blow_irq_en_pos = 4;
  localparam int bsw_tstamp_en_pos = 5;

  // status register field positions
  localparam int bsw_flag_pos = 0;
  localparam int blow_flag_pos = 1;
  localparam int on_battery_pos = 2;
  localparam int blow_det_pos = 3;
  localparam int pfail_det_pos = 4;

  // clear register: writing one here clears the battery-switch flag
  localparam int clr_bsw_pos = 0;

  localparam logic [2:0] mode_rst = 3'h0;
  localparam logic [data_w-1:0] ctrl_rst = 8'h00;

  typedef enum logic [1:0] {
    sw_standard = 2'b00,
    sw_direct = 2'b01,
    sw_disabled = 2'b10
  } switch_mode_t;

  typedef struct packed {
    logic vdd_below_bat;
    logic vdd_below_thr;
    logic bat_below_low;
  } cmp_t;

  typedef struct packed {
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage
